// ==== shared/hpp_pkg.sv ====
// package for the host parallel bus port: modes, address widths, status layout
package hpp_pkg;
   localparam int HPP_DATA_W = 8;
   localparam int HPP_SEP_ADDR_W = 6;
   localparam int HPP_IRQ_W = 8;
   // main status register address and bits that survive its read
   localparam logic [7:0] HPP_IRQ_STATUS_ADDR = 8'h20;
   localparam int HPP_BIT_EXT = 0;
   localparam int HPP_BIT_CHG = 2;
   localparam logic [7:0] HPP_KEEP_ON_READ = 8'h05;
   localparam logic [7:0] HPP_STATUS_RST = 8'h00;
   localparam logic [7:0] HPP_ADDR_RST = 8'h00;
   localparam logic [5:0] HPP_PULL_LOW = 6'h00;
   // style codes shown on mode_o
   localparam logic [1:0] HPP_CODE_SEP = 2'h0;
   localparam logic [1:0] HPP_CODE_RWDS = 2'h1;
   localparam logic [1:0] HPP_CODE_MUX = 2'h2;

   typedef enum logic [2:0] {
      HPP_MODE_SEPSTRB = 3'b001,
      HPP_MODE_RWDS = 3'b010,
      HPP_MODE_MUX = 3'b100
   } hpp_mode_t;

   // one register access presented to the core
   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic wr;
      logic rd;
   } hpp_access_t;
endpackage

// ==== src/hpp_irq_status.sv ====
// interrupt status holder with clear-on-read and open-drain request drive
`timescale 1ns/1ps
`default_nettype none
module hpp_irq_status
   import hpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] irq_events,
   input wire logic status_read,
   output logic [7:0] irq_status_reg,
   output logic irq_n_o,
   output logic irq_n_oe
);
   logic [7:0] status_next;
   // set wins over the read clear
   assign status_next = (status_read ? (irq_status_reg & HPP_KEEP_ON_READ) : irq_status_reg)
                        | irq_events;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         irq_status_reg <= HPP_STATUS_RST;
      end else begin
         irq_status_reg <= status_next;
      end
   end
   // open drain: drive low only, released when every bit clear
   assign irq_n_o = 1'b0;
   assign irq_n_oe = |irq_status_reg;
endmodule
`default_nettype wire

// ==== src/hpp_port.sv ====
// host parallel bus port: three bus styles, address decode, register access strobes
`timescale 1ns/1ps
`default_nettype none
module hpp_port
   import hpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chip_sel_n,
   input wire logic latch_strobe,
   input wire logic wr_n_rw,
   input wire logic rd_n_data_strobe_n,
   input wire logic [7:0] bus_line_i,
   output logic [7:0] bus_line_o,
   output logic bus_line_oe,
   input wire logic [4:0] sep_addr_bits,
   input wire logic sep_addr_bit_5,
   output logic sep_addr_pull_o,
   output logic sep_addr_pull_oe,
   output logic external_awake,
   output logic [1:0] mode_o,
   input wire logic [7:0] reg_rdata,
   input wire logic [7:0] irq_events,
   output hpp_access_t acc_o,
   output logic [7:0] irq_status_reg,
   output logic irq_n_o,
   output logic irq_n_oe
);
   hpp_mode_t mode_reg;
   hpp_mode_t mode_next;
   logic strap_done_reg;
   logic ale_prev_reg;
   logic [7:0] mux_addr_reg;
   // bit 0: write or direction pin, bit 1: read or data strobe pin
   logic [1:0] strb_pin;
   wire [1:0] strb_rise;
   hpp_access_t acc_reg;
   hpp_access_t acc_next;
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;

   // one decode of the status address serves both the read select and the clear
   function automatic logic addr_is_status(input logic [7:0] addr);
      return addr == HPP_IRQ_STATUS_ADDR;
   endfunction

   // style code on mode_o; an illegal one-hot value shows as separate strobes
   function automatic logic [1:0] mode_code(input hpp_mode_t m);
      logic [1:0] code;
      code = HPP_CODE_SEP;
      unique case (m)
         HPP_MODE_SEPSTRB: begin
            code = HPP_CODE_SEP;
         end
         HPP_MODE_RWDS: begin
            code = HPP_CODE_RWDS;
         end
         HPP_MODE_MUX: begin
            code = HPP_CODE_MUX;
         end
         default: begin
            code = HPP_CODE_SEP;
         end
      endcase
      return code;
   endfunction

   // edges of the sampled pins
   wire ale_edge = strap_done_reg && (latch_strobe != ale_prev_reg);
   wire ale_fall = ale_prev_reg && !latch_strobe;
   wire selected = !chip_sel_n;
   wire is_mux = (mode_reg == HPP_MODE_MUX);
   wire is_rwds = (mode_reg == HPP_MODE_RWDS);
   wire [7:0] sep_addr = {2'b00, sep_addr_bit_5, sep_addr_bits};
   wire [7:0] cur_addr = is_mux ? mux_addr_reg : sep_addr;

   // access ends: strobe rising edges
   assign strb_pin = {rd_n_data_strobe_n, wr_n_rw};
   wire ds_rise = strb_rise[1];
   wire rd_rise = strb_rise[1];
   wire wr_rise = strb_rise[0];
   wire rwds_wr = is_rwds && selected && ds_rise && !wr_n_rw;
   wire rwds_rd = is_rwds && selected && ds_rise && wr_n_rw;
   wire sep_wr = !is_rwds && selected && wr_rise;
   wire sep_rd = !is_rwds && selected && rd_rise;
   // read drive window: strobe low with the device selected
   wire rd_active = selected && !rd_n_data_strobe_n && (is_rwds ? wr_n_rw : 1'b1);

   // both strobe pins idle high: history resets high so no edge follows reset
   for (genvar i = 0; i < 2; i++) begin : g_strb
      logic prev_reg;
      always_ff @(posedge ref_clk or posedge reset) begin
         if (reset) begin
            prev_reg <= 1'b1;
         end else begin
            prev_reg <= strb_pin[i];
         end
      end
      assign strb_rise[i] = !prev_reg && strb_pin[i];
   end

   // mode: first sampled level after reset, then any edge locks multiplexed
   always_comb begin
      mode_next = mode_reg;
      unique case (mode_reg)
         HPP_MODE_SEPSTRB, HPP_MODE_RWDS: begin
            if (ale_edge) begin
               mode_next = HPP_MODE_MUX;
            end
         end
         HPP_MODE_MUX: begin
            mode_next = HPP_MODE_MUX;
         end
         default: begin
            mode_next = HPP_MODE_SEPSTRB;
         end
      endcase
      if (!strap_done_reg) begin
         mode_next = latch_strobe ? HPP_MODE_RWDS : HPP_MODE_SEPSTRB;
      end
   end

   always_comb begin
      acc_next.addr = cur_addr;
      acc_next.wdata = bus_line_i;
      acc_next.wr = rwds_wr || sep_wr;
      acc_next.rd = rwds_rd || sep_rd;
   end

   // style register: only the asynchronous reset brings it out of multiplexed
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mode_reg <= HPP_MODE_SEPSTRB;
      end else begin
         mode_reg <= mode_next;
      end
   end

   // the strap is taken once, at the first edge after reset
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         strap_done_reg <= 1'b0;
      end else begin
         strap_done_reg <= 1'b1;
      end
   end

   // history starts low; a strapped-high pin is masked by the strap gate once
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         ale_prev_reg <= 1'b0;
      end else begin
         ale_prev_reg <= latch_strobe;
      end
   end

   // address held from latch fall until the next one
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         mux_addr_reg <= HPP_ADDR_RST;
      end else if (ale_fall) begin
         mux_addr_reg <= bus_line_i;
      end
   end

   // access pulses stand one cycle, so the core sees each access once
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         acc_reg <= '0;
      end else begin
         acc_reg <= acc_next;
      end
   end

   // read data lags the address by a cycle; strobes shorter than one cycle miss it
   assign rdata_next = addr_is_status(cur_addr) ? irq_status_reg : reg_rdata;
   always_ff @(posedge ref_clk or posedge reset) begin
      if (reset) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end

   wire status_read = acc_next.rd && addr_is_status(cur_addr);

   hpp_irq_status u_irq (
      .ref_clk(ref_clk),
      .reset(reset),
      .irq_events(irq_events),
      .status_read(status_read),
      .irq_status_reg(irq_status_reg),
      .irq_n_o(irq_n_o),
      .irq_n_oe(irq_n_oe)
   );

   assign acc_o = acc_reg;
   assign bus_line_o = rdata_reg;
   assign bus_line_oe = rd_active && !(is_mux && latch_strobe);
   // weak pull-down modelled as a drive low in multiplexed style
   assign sep_addr_pull_o = 1'b0;
   assign sep_addr_pull_oe = is_mux;
   // awake only usable in multiplexed style; pin is an address otherwise
   assign external_awake = is_mux && sep_addr_bit_5;
   assign mode_o = mode_code(mode_reg);
endmodule
`default_nettype wire

// ==== test/hpp_checker.sv ====
// assertions on the host port outputs
`timescale 1ns/1ps
`default_nettype none
module hpp_checker
   import hpp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic chip_sel_n,
   input wire logic latch_strobe,
   input wire logic bus_line_oe,
   input wire logic sep_addr_pull_o,
   input wire logic sep_addr_pull_oe,
   input wire logic external_awake,
   input wire logic sep_addr_bit_5,
   input wire logic [1:0] mode_o,
   input wire logic [7:0] irq_events,
   input wire hpp_access_t acc_o,
   input wire logic [7:0] irq_status_reg,
   input wire logic irq_n_o,
   input wire logic irq_n_oe
);
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (reset);
   chk_sel_gate: assert property (bus_line_oe |-> !chip_sel_n) else $error("oe unsel");
   chk_irq_level: assert property (irq_n_oe == (irq_status_reg != 8'h00) && !irq_n_o)
      else $error("irq drive");
   chk_mux_stay: assert property (mode_o == 2'd2 |=> mode_o == 2'd2) else $error("left mux");
   chk_edge_mux: assert property ($changed(latch_strobe) |-> ##[0:2] mode_o == 2'd2)
      else $error("edge no mux");
   chk_pull_mux: assert property (sep_addr_pull_oe == (mode_o == 2'd2) && !sep_addr_pull_o)
      else $error("pull");
   chk_awake_off: assert property (mode_o != 2'd2 |-> !external_awake) else $error("awake");
   chk_awake_pass: assert property (mode_o == HPP_CODE_MUX |-> external_awake == sep_addr_bit_5)
      else $error("awake pass");
   chk_one_dir: assert property (!(acc_o.wr && acc_o.rd)) else $error("wr and rd");
   chk_status_clr: assert property (acc_o.rd && acc_o.addr == HPP_IRQ_STATUS_ADDR
      && $past(irq_events) == 8'h00 |-> (irq_status_reg & ~HPP_KEEP_ON_READ) == 8'h00)
      else $error("clr");
   cover property (acc_o.wr && mode_o == 2'd2);
   cover property (acc_o.rd && mode_o == 2'd1);
   cover property ($fell(irq_n_oe));
endmodule
bind hpp_port hpp_checker chk (.*);
`default_nettype wire

// ==== test/hpp_host_model.sv ====
// host processor model for the three bus styles
`timescale 1ns/1ps
`default_nettype none
module hpp_host_model (
   input wire logic ref_clk,
   input wire logic [7:0] bus_line_o,
   input wire logic bus_line_oe,
   output logic chip_sel_n = 1'b1,
   output logic latch_strobe = 1'b0,
   output logic wr_n_rw = 1'b1,
   output logic rd_n_data_strobe_n = 1'b1,
   output logic [7:0] bus_line_i,
   output logic [4:0] sep_addr_bits = 5'h00,
   output logic sep_addr_bit_5 = 1'b0
);
   logic [7:0] drv_val = 8'h00;
   logic drv_on = 1'b0;
   logic [7:0] rdata;
   // floating bus shows the inverse, never a stale copy
   assign bus_line_i = drv_on ? drv_val : bus_line_oe ? bus_line_o : ~drv_val;
   task automatic strap(input logic s);
      latch_strobe = s;
   endtask
   task automatic acc(input logic [1:0] m, input logic cs, w, input logic [7:0] a, d);
      @(negedge ref_clk);
      chip_sel_n = cs;
      {sep_addr_bit_5, sep_addr_bits} = a[5:0];
      drv_on = 1'b1;
      drv_val = a;
      if (m == 2'd2) begin
         latch_strobe = 1'b1;
         repeat (2) @(negedge ref_clk);
         latch_strobe = 1'b0;
         @(negedge ref_clk);
      end
      drv_on = w;
      drv_val = d;
      wr_n_rw = !w;
      rd_n_data_strobe_n = (m != 2'd1) && w;
      repeat (3) @(negedge ref_clk);
      rdata = bus_line_i;
      // direction line stays valid across the closing strobe edge
      rd_n_data_strobe_n = 1'b1;
      if (m != 2'd1) wr_n_rw = 1'b1;
      @(negedge ref_clk);
      wr_n_rw = 1'b1;
      chip_sel_n = 1'b1;
      drv_on = 1'b0;
   endtask
endmodule
`default_nettype wire

// ==== test/hpp_port_bench.sv ====
// self-checking bench for the host port
`timescale 1ns/1ps
`default_nettype none
module hpp_port_bench;
   import hpp_pkg::*;
   logic ref_clk = 1'b0;
   logic reset = 1'b1;
   logic chip_sel_n, latch_strobe, wr_n_rw, rd_n_data_strobe_n, bus_line_oe, sep_addr_bit_5;
   logic sep_addr_pull_o, sep_addr_pull_oe, external_awake, irq_n_o, irq_n_oe;
   logic [7:0] bus_line_i, bus_line_o, irq_status_reg, ev;
   logic [7:0] reg_rdata = 8'h00;
   logic [7:0] irq_events = 8'h00;
   logic [4:0] sep_addr_bits;
   logic [1:0] mode_o;
   hpp_access_t acc_o, got;
   int n_mismatch = 0, checks = 0, n_acc = 0, seed = 32'hc57b;
   hpp_port uut (.*);
   hpp_host_model host (.*);
   always #25 ref_clk = ~ref_clk;
   always @(posedge ref_clk) if (acc_o.wr || acc_o.rd) begin
      got <= acc_o;
      n_acc <= n_acc + 1;
   end
   function automatic logic [7:0] exp_addr(input logic [1:0] m, input logic [7:0] a);
      return (m == 2'd2) ? a : {2'b00, a[5:0]};
   endfunction
   task automatic chk(input logic [7:0] g, e);
      checks++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic summarize;
      $display("mismatches=%0d checks=%0d", n_mismatch, checks);
      if (n_mismatch == 0 && checks > 0) $display("ALL CHECKS OK");
      else $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic rst(input logic s);
      reset = 1'b1;
      host.strap(s);
      repeat (8) @(negedge ref_clk);
      reset = 1'b0;
      repeat (2) @(negedge ref_clk);
      chk({6'h00, mode_o}, {7'h00, s});
   endtask
   task automatic op(input logic [1:0] m, input logic cs, w, input logic [7:0] a);
      logic [7:0] d;
      int n0;
      d = 8'($random(seed));
      reg_rdata = 8'($random(seed));
      n0 = n_acc;
      host.acc(m, cs, w, a, d);
      repeat (3) @(negedge ref_clk);
      chk(8'(n_acc - n0), {7'h00, !cs});
      if (!cs) begin
         chk(got.addr, exp_addr(m, a));
         chk({6'h00, got.wr, got.rd}, {6'h00, w, !w});
         if (w || exp_addr(m, a) != HPP_IRQ_STATUS_ADDR) chk(w ? got.wdata : host.rdata, w ? d : reg_rdata);
      end
   endtask
   initial begin
      for (int s = 0; s < 2; s++) begin
         rst(s[0]);
         op(2'(s), 1'b0, 1'b1, 8'h3f);
         op(2'(s), 1'b1, 1'b0, 8'h01);
         repeat (6) op(2'(s), 1'b0, 1'($random(seed)), 8'($random(seed)));
      end
      host.strap(1'b0);
      repeat (3) @(negedge ref_clk);
      repeat (6) op(2'd2, 1'b0, 1'($random(seed)), 8'($random(seed)) | 8'h40);
      chk({5'h00, mode_o, sep_addr_pull_oe}, 8'h05);
      chk({7'h00, external_awake}, {7'h00, sep_addr_bit_5});
      for (int k = 0; k < 2; k++) begin
         ev = 8'($random(seed)) & 8'hfa | (k ? 8'h05 : 8'h02);
         irq_events = ev;
         @(negedge ref_clk);
         irq_events = 8'h00;
         repeat (2) @(negedge ref_clk);
         chk({irq_n_oe, 7'h00}, 8'h80);
         op(2'd2, 1'b0, 1'b0, HPP_IRQ_STATUS_ADDR);
         chk(host.rdata, ev);
         chk(irq_status_reg, ev & HPP_KEEP_ON_READ);
         chk({7'h00, irq_n_oe}, {7'h00, k[0]});
      end
      rst(1'b0);
      summarize();
   end
   initial begin
      #200us;
      n_mismatch++;
      summarize();
   end
endmodule
`default_nettype wire
